// [core/alo_pkg.sv]
// constants and types for the accumulator logic operation block
package alo_pkg;

    // ========================================================================
    // instruction word layout
    localparam int        ALO_WORD_W    = 10;
    localparam int        ALO_HI_MSB    = 9;
    localparam int        ALO_HI_LSB    = 5;
    localparam int        ALO_LO_MSB    = 4;
    localparam int        ALO_FORM_BIT  = 4;
    localparam int        ALO_IMM_MSB   = 3;

    // ========================================================================
    // upper five bits of the stored word
    localparam logic [4:0] ALO_HI_AND_R0 = 5'h1b;
    localparam logic [4:0] ALO_HI_AND_R1 = 5'h1a;
    localparam logic [4:0] ALO_HI_OR_R0  = 5'h1d;
    localparam logic [4:0] ALO_HI_OR_R1  = 5'h1c;
    localparam logic [4:0] ALO_HI_XOR_R0 = 5'h15;
    localparam logic [4:0] ALO_HI_XOR_R1 = 5'h14;
    localparam logic [4:0] ALO_HI_INC    = 5'h14;
    localparam logic [4:0] ALO_HI_ROT    = 5'h1c;
    localparam logic [4:0] ALO_HI_ROTZ   = 5'h1e;

    // ========================================================================
    // lower five bits of the stored word
    localparam logic [4:0] ALO_LO_TABLE  = 5'h10;
    localparam logic [4:0] ALO_LO_IMM    = 5'h11;
    localparam logic [4:0] ALO_LO_ACC    = 5'h13;

    // ========================================================================
    // reset values
    localparam logic [3:0] ALO_ACC_RST   = 4'h0;
    localparam logic       ALO_CY_RST    = 1'b0;

    typedef enum logic [2:0] {
        ALO_OP_NONE,
        ALO_OP_AND,
        ALO_OP_OR,
        ALO_OP_XOR,
        ALO_OP_INC,
        ALO_OP_ROT,
        ALO_OP_ROTZ
    } alo_op_e;

    typedef enum logic [1:0] {
        ALO_SRC_REG,
        ALO_SRC_TABLE,
        ALO_SRC_IMM
    } alo_src_e;

    typedef struct packed {
        logic [3:0] acc;
        logic       cy;
        logic       done;
        logic       rreq;
    } alo_state_s;

endpackage : alo_pkg

// [core/alo_alu_if.sv]
// link between the operation core and its nibble alu
`timescale 1ns/1ps
interface alo_alu_if;
    alo_pkg::alo_op_e op;
    logic [3:0]       a;
    logic [3:0]       b;
    logic [3:0]       res;
    logic             cy;

    modport core (output op, output a, output b, input res, input cy);
    modport alu  (input op, input a, input b, output res, output cy);
endinterface : alo_alu_if

// [core/alo_alu.sv]
// combinational nibble alu with carry rules
`timescale 1ns/1ps
module alo_alu (
    alo_alu_if.alu p
);
    logic [3:0] sum;

    assign sum = 4'(p.a + 4'h1);

    always_comb
    begin
        p.res = p.a;
        p.cy  = 1'b0;
        case (p.op)
            alo_pkg::ALO_OP_AND:
            begin
                p.res = p.a & p.b;
                p.cy  = p.a[3] & p.b[3];
            end
            alo_pkg::ALO_OP_OR:
            begin
                p.res = p.a | p.b;
                p.cy  = 1'b0;
            end
            alo_pkg::ALO_OP_XOR:
            begin
                p.res = p.a ^ p.b;
                p.cy  = p.a[3] & p.b[3];
            end
            alo_pkg::ALO_OP_INC:
            begin
                p.res = sum;
                p.cy  = (sum == 4'h0);
            end
            alo_pkg::ALO_OP_ROT, alo_pkg::ALO_OP_ROTZ:
            begin
                p.res = {p.a[2:0], p.a[3]};
                p.cy  = p.a[3];
            end
            default:
            begin
                p.res = p.a;
                p.cy  = 1'b0;
            end
        endcase
    end
endmodule : alo_alu

// [core/alo_core.sv]
// accumulator logic operation execution core
`timescale 1ns/1ps
module alo_core (
    input  wire logic        sys_clk,
    input  wire logic        rst,
    input  wire logic        instr_valid,
    input  wire logic [9:0]  instr_word,
    input  wire logic [9:0]  instr_next_word,
    output logic             reg_bank,
    output logic [3:0]       reg_index,
    input  wire logic [3:0]  reg_rdata,
    input  wire logic [2:0]  table_page_port,
    input  wire logic [7:0]  table_pointer_reg,
    output logic [10:0]      table_addr,
    input  wire logic [9:0]  table_rom_data,
    input  wire logic        acc_load_en,
    input  wire logic [3:0]  acc_load_data,
    output logic             op_hit,
    output logic [3:0]       acc_value,
    output logic             carry_flag,
    output logic             op_done,
    output logic             core_reset_req
);
    // ========================================================================
    // decode
    logic [4:0]          hi;
    logic [4:0]          lo;
    alo_pkg::alo_op_e    op_sel;
    alo_pkg::alo_src_e   src_sel;
    logic                tbl_high;
    logic [3:0]          operand;
    logic                fire;
    alo_pkg::alo_state_s state_q;
    alo_pkg::alo_state_s state_d;
    alo_alu_if           alu_link ();

    assign hi = instr_word[alo_pkg::ALO_HI_MSB:alo_pkg::ALO_HI_LSB];
    assign lo = instr_word[alo_pkg::ALO_LO_MSB:0];

    always_comb
    begin
        op_sel   = alo_pkg::ALO_OP_NONE;
        src_sel  = alo_pkg::ALO_SRC_REG;
        tbl_high = ~hi[0];
        if (!lo[alo_pkg::ALO_FORM_BIT])
        begin
            if (hi == alo_pkg::ALO_HI_AND_R0 || hi == alo_pkg::ALO_HI_AND_R1)
                op_sel = alo_pkg::ALO_OP_AND;
            else if (hi == alo_pkg::ALO_HI_OR_R0 || hi == alo_pkg::ALO_HI_OR_R1)
                op_sel = alo_pkg::ALO_OP_OR;
            else if (hi == alo_pkg::ALO_HI_XOR_R0 || hi == alo_pkg::ALO_HI_XOR_R1)
                op_sel = alo_pkg::ALO_OP_XOR;
        end
        else if (lo == alo_pkg::ALO_LO_TABLE)
        begin
            src_sel = alo_pkg::ALO_SRC_TABLE;
            // even upper field picks the high nibble
            if (hi == alo_pkg::ALO_HI_AND_R0 || hi == alo_pkg::ALO_HI_AND_R1)
                op_sel = alo_pkg::ALO_OP_AND;
            else if (hi == alo_pkg::ALO_HI_OR_R0 || hi == alo_pkg::ALO_HI_OR_R1)
                op_sel = alo_pkg::ALO_OP_OR;
            else if (hi == alo_pkg::ALO_HI_XOR_R0 || hi == alo_pkg::ALO_HI_XOR_R1)
                op_sel = alo_pkg::ALO_OP_XOR;
        end
        else if (lo == alo_pkg::ALO_LO_IMM)
        begin
            src_sel = alo_pkg::ALO_SRC_IMM;
            if (hi == alo_pkg::ALO_HI_AND_R0)
                op_sel = alo_pkg::ALO_OP_AND;
            else if (hi == alo_pkg::ALO_HI_OR_R0)
                op_sel = alo_pkg::ALO_OP_OR;
            else if (hi == alo_pkg::ALO_HI_XOR_R0)
                op_sel = alo_pkg::ALO_OP_XOR;
        end
        else if (lo == alo_pkg::ALO_LO_ACC)
        begin
            if (hi == alo_pkg::ALO_HI_INC)
                op_sel = alo_pkg::ALO_OP_INC;
            else if (hi == alo_pkg::ALO_HI_ROT)
                op_sel = alo_pkg::ALO_OP_ROT;
            else if (hi == alo_pkg::ALO_HI_ROTZ)
                op_sel = alo_pkg::ALO_OP_ROTZ;
        end
    end

    // ========================================================================
    // operand fetch
    assign reg_bank   = ~hi[0];
    assign reg_index  = lo[3:0];
    assign table_addr = {table_page_port, table_pointer_reg};
    assign op_hit     = (op_sel != alo_pkg::ALO_OP_NONE);
    assign fire       = instr_valid && op_hit;

    always_comb
    begin
        if (src_sel == alo_pkg::ALO_SRC_TABLE)
            operand = tbl_high ? table_rom_data[7:4] : table_rom_data[3:0];
        else if (src_sel == alo_pkg::ALO_SRC_IMM)
            operand = instr_next_word[alo_pkg::ALO_IMM_MSB:0];
        else
            operand = reg_rdata;
    end

    assign alu_link.op = op_sel;
    assign alu_link.a  = state_q.acc;
    assign alu_link.b  = operand;

    alo_alu u_alu (
        .p (alu_link.alu)
    );

    // ========================================================================
    // state
    always_comb
    begin
        state_d      = state_q;
        state_d.done = 1'b0;
        state_d.rreq = 1'b0;
        if (fire)
        begin
            state_d.done = 1'b1;
            if (op_sel == alo_pkg::ALO_OP_ROTZ && state_q.acc == 4'h0)
            begin
                state_d.rreq = 1'b1;
                state_d.cy   = alo_pkg::ALO_CY_RST;
            end
            else
            begin
                state_d.acc = alu_link.res;
                state_d.cy  = alu_link.cy;
            end
        end
        else if (acc_load_en)
        begin
            state_d.acc = acc_load_data;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            state_q.acc  <= alo_pkg::ALO_ACC_RST;
            state_q.cy   <= alo_pkg::ALO_CY_RST;
            state_q.done <= 1'b0;
            state_q.rreq <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
        end
    end

    assign acc_value      = state_q.acc;
    assign carry_flag     = state_q.cy;
    assign op_done        = state_q.done;
    assign core_reset_req = state_q.rreq;

    // ========================================================================
    // checks
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    AST_AND_REG: assert property (instr_valid && !instr_word[4] && hi == 5'h1b
        |=> acc_value == ($past(acc_value) & $past(reg_rdata))
            && carry_flag == ($past(acc_value[3]) & $past(reg_rdata[3])))
        else $error("register and result wrong");
    AST_AND_TBL_HI: assert property (instr_valid && lo == 5'h10 && hi == 5'h1a
        |=> acc_value == ($past(acc_value) & $past(table_rom_data[7:4]))
            && carry_flag == ($past(acc_value[3]) & $past(table_rom_data[7])))
        else $error("table high and wrong");
    AST_AND_IMM: assert property (instr_valid && lo == 5'h11 && hi == 5'h1b
        |=> acc_value == ($past(acc_value) & $past(instr_next_word[3:0]))
            && carry_flag == ($past(acc_value[3]) & $past(instr_next_word[3])))
        else $error("immediate and wrong");
    AST_OR_CLEARS: assert property (instr_valid && op_sel == alo_pkg::ALO_OP_OR
        |=> !carry_flag && op_done)
        else $error("or left carry set");
    AST_OR_TBL_LO: assert property (instr_valid && lo == 5'h10 && hi == 5'h1d
        |=> acc_value == ($past(acc_value) | $past(table_rom_data[3:0])))
        else $error("table low or wrong");
    AST_XOR_REG: assert property (instr_valid && !instr_word[4] && hi == 5'h14
        |=> acc_value == ($past(acc_value) ^ $past(reg_rdata))
            && carry_flag == ($past(acc_value[3]) & $past(reg_rdata[3])))
        else $error("register xor wrong");
    AST_XOR_TBL_LO: assert property (instr_valid && lo == 5'h10 && hi == 5'h15
        |=> carry_flag == ($past(acc_value[3]) & $past(table_rom_data[3])))
        else $error("table low xor carry wrong");
    AST_INC: assert property (instr_valid && lo == 5'h13 && hi == 5'h14
        |=> acc_value == 4'($past(acc_value) + 4'h1) && carry_flag == (acc_value == 4'h0))
        else $error("increment wrong");
    AST_ROT: assert property (instr_valid && lo == 5'h13 && hi == 5'h1c
        |=> acc_value == {$past(acc_value[2:0]), $past(acc_value[3])}
            && carry_flag == $past(acc_value[3]))
        else $error("rotate wrong");
    AST_ROTZ_RESET: assert property (instr_valid && lo == 5'h13 && hi == 5'h1e
        && acc_value == 4'h0 |=> core_reset_req && !carry_flag ##1 !core_reset_req)
        else $error("zero rotate did not reset");
    AST_ROTZ_NORESET: assert property (instr_valid && lo == 5'h13 && hi == 5'h1e
        && acc_value != 4'h0 |=> !core_reset_req && carry_flag == $past(acc_value[3]))
        else $error("nonzero rotate misbehaved");
    AST_ONE_CYCLE: assert property (fire |=> op_done ##1 (op_done == $past(fire)))
        else $error("operation took more than one cycle");
endmodule : alo_core

// [tb/alo_testbench.sv]
// self-checking bench for the accumulator logic operation core
`timescale 1ns/1ps
`define CHK(got, exp, msg) \
    begin \
        check_count++; \
        if ((got) !== (exp)) \
        begin \
            errors++; \
            $display("[FAIL] %0t %s", $time, msg); \
        end \
    end
module testbench;
    // ========================================================================
    // signals
    logic        sys_clk, rst, instr_valid, acc_load_en;
    logic [9:0]  instr_word, instr_next_word, table_rom_data;
    logic        reg_bank, op_hit, carry_flag, op_done, core_reset_req;
    logic [3:0]  reg_index, reg_rdata, acc_load_data, acc_value;
    logic [2:0]  table_page_port;
    logic [7:0]  table_pointer_reg;
    logic [10:0] table_addr;
    logic [3:0]  regs [32];
    logic [3:0]  acc_m;
    logic        cy_m;
    int          errors, check_count, cycles;
    logic [15:0] ops [18] = '{16'hfbe3, 16'hfae5, 16'hfaf0, 16'hfbf0, 16'hfbf1, 16'hfde7,
                              16'hfcea, 16'hfcf0, 16'hfdf0, 16'hfdf1, 16'hf5ec, 16'hf4ef,
                              16'hf4f0, 16'hf5f0, 16'hf5f1, 16'hf4f3, 16'hfcf3, 16'hfef3};

    function automatic logic [9:0] rom_f(input logic [10:0] a);
        // page msb folded in so every address bit reaches the data
        return a[9:0] ^ {a[10], 9'h000} ^ 10'h2c9;
    endfunction : rom_f

    assign reg_rdata      = regs[{reg_bank, reg_index}];
    assign table_rom_data = rom_f(table_addr);

    alo_core DUT (.sys_clk(sys_clk), .rst(rst), .instr_valid(instr_valid),
        .instr_word(instr_word), .instr_next_word(instr_next_word), .reg_bank(reg_bank),
        .reg_index(reg_index), .reg_rdata(reg_rdata), .table_page_port(table_page_port),
        .table_pointer_reg(table_pointer_reg), .table_addr(table_addr),
        .table_rom_data(table_rom_data), .acc_load_en(acc_load_en),
        .acc_load_data(acc_load_data), .op_hit(op_hit), .acc_value(acc_value),
        .carry_flag(carry_flag), .op_done(op_done), .core_reset_req(core_reset_req));

    // ========================================================================
    // clock and timeout
    initial
    begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    always @(posedge sys_clk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            errors++;
            $display("[FAIL] %0t timeout", $time);
            wrap_up();
        end
    end

    // ========================================================================
    // tasks
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", check_count, errors);
        if (errors == 0 && check_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : wrap_up

    // executes one published opcode; stored word built from its bits 12-8 and 4-0
    task automatic run(input logic [15:0] op, input logic [3:0] imm);
        logic [4:0] hi, lo;
        logic [3:0] b;
        logic [9:0] w;
        logic       zr;
        hi = op[12:8];
        lo = op[4:0];
        zr = 1'b0;
        w  = rom_f({table_page_port, table_pointer_reg});
        b  = (lo == 5'h11) ? imm : (lo == 5'h10) ? (hi[0] ? w[3:0] : w[7:4])
                                                 : regs[{~hi[0], op[3:0]}];
        instr_valid     = 1'b1;
        instr_word      = {hi, lo};
        instr_next_word = {6'h00, imm};
        #1 `CHK(op_hit, 1'b1, "op not decoded")
        if (lo == 5'h13)
        begin
            if (hi == 5'h14)
            begin
                acc_m = acc_m + 4'h1;
                cy_m  = (acc_m == 4'h0);
            end
            else if (hi == 5'h1e && acc_m == 4'h0)
            begin
                zr   = 1'b1;
                cy_m = 1'b0;
            end
            else
            begin
                cy_m  = acc_m[3];
                acc_m = {acc_m[2:0], acc_m[3]};
            end
        end
        else if (hi == 5'h1a || hi == 5'h1b)
        begin
            cy_m  = acc_m[3] & b[3];
            acc_m = acc_m & b;
        end
        else if (hi == 5'h1c || hi == 5'h1d)
        begin
            cy_m  = 1'b0;
            acc_m = acc_m | b;
        end
        else
        begin
            cy_m  = acc_m[3] & b[3];
            acc_m = acc_m ^ b;
        end
        @(posedge sys_clk);
        @(negedge sys_clk);
        `CHK(acc_value, acc_m, "accumulator")
        `CHK(carry_flag, cy_m, "carry")
        `CHK(op_done, 1'b1, "done pulse")
        `CHK(core_reset_req, zr, "reset request")
    endtask : run

    // one cycle without a firing op; nothing may change
    task automatic idle(input logic vld, input logic [9:0] word, input logic hit);
        instr_valid = vld;
        instr_word  = word;
        #1 `CHK(op_hit, hit, "decode hit")
        @(posedge sys_clk);
        @(negedge sys_clk);
        `CHK(acc_value, acc_m, "acc held")
        `CHK(op_done, 1'b0, "done low")
        `CHK(core_reset_req, 1'b0, "request low")
    endtask : idle

    task automatic load(input logic [3:0] d);
        instr_valid   = 1'b0;
        acc_load_en   = 1'b1;
        acc_load_data = d;
        @(posedge sys_clk);
        @(negedge sys_clk);
        acc_load_en = 1'b0;
        acc_m       = d;
        `CHK(acc_value, d, "load")
    endtask : load

    // ========================================================================
    // tests
    initial
    begin
        rst = 1'b1;
        instr_valid = 1'b0;
        acc_load_en = 1'b0;
        acc_load_data = 4'h0;
        instr_word = 10'h000;
        instr_next_word = 10'h000;
        table_page_port = 3'h5;
        table_pointer_reg = 8'h3c;
        for (int i = 0; i < 32; i++)
            regs[i] = 4'(i * 5) ^ (i >= 16 ? 4'hb : 4'h0);
        repeat (10) @(posedge sys_clk);
        @(negedge sys_clk);
        rst = 1'b0;
        acc_m = 4'h0;
        `CHK(acc_value, 4'h0, "acc reset")
        `CHK(carry_flag, 1'b0, "carry reset")
        for (int k = 0; k < 2; k++)
        begin
            table_page_port   = k ? 3'h2 : 3'h5;
            table_pointer_reg = k ? 8'hd7 : 8'h3c;
            load(k ? 4'ha : 4'h7);
            foreach (ops[i])
                run(ops[i], 4'(i * 3 + k * 5 + 9));
        end
        idle(1'b0, 10'h000, 1'b0);
        $display("test ops done");
        load(4'hf);
        run(16'hf4f3, 4'h0);
        run(16'hfef3, 4'h0);
        idle(1'b0, 10'h393, 1'b1);
        load(4'h8);
        run(16'hfef3, 4'h0);
        $display("test wrap and zero rotate done");
        idle(1'b1, 10'h3e0, 1'b0);
        acc_load_en   = 1'b1;
        acc_load_data = 4'h9;
        run(16'hfdf1, 4'h2);
        acc_load_en = 1'b0;
        // leave carry set so the second reset has something to clear
        load(4'h9);
        run(16'hfcf3, 4'h0);
        idle(1'b0, 10'h000, 1'b0);
        rst = 1'b1;
        @(posedge sys_clk);
        @(negedge sys_clk);
        rst = 1'b0;
        `CHK(acc_value, 4'h0, "acc reset again")
        `CHK(carry_flag, 1'b0, "carry reset again")
        $display("test refusal and reset done");
        wrap_up();
    end
endmodule : testbench
